//--- logic/scic_top.sv
// Step command decoder and parameter store with an APB slave.
//
// What this block does
// RULE1 - Steps come as step plus direction, or as separate cw and ccw pulses.
// RULE2 - Configuration picks rising or falling edge as the counting edge.
// RULE3 - In dual pulse format the idle input's static level never matters.
// RULE4 - Configuration picks which direction level means default rotation.
// RULE5 - Direction polarity applies only in step plus direction format.
// RULE6 - Microstep resolution 1 to 512 scales every command pulse.
// RULE7 - Peak current from the link, clamped to 0.5 to 5.6 A, or unclamped from the board switches.
// RULE8 - Damping coefficient resets to 3000.
// RULE9 - Two switch changes within one second start motor identification.
// RULE10 - Configuration link runs at 38400 baud by default.
// RULE11 - Parameters written by the host are stored and used.
// RULE12 - The host can read back every stored parameter.
// RULE13 - Proportional and integral current gains are stored separately.
// RULE14 - Host requested current step test runs and may be restarted.
// RULE15 - Internal pulse generator can drive the motor instead.
// RULE16 - Inputs are synchronised before edge detection, one step per edge except cw and ccw edges in the same cycle, which give none.
// RULE17 - A lone switch change is an ordinary setting change.
`timescale 1ns/100ps
module scic_top #(
    parameter int ID_WINDOW = scic_pkg::ID_WINDOW_CYC,
    parameter int POS_W     = 32
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              step_pulse_input,
    input  wire logic              direction_input,
    input  wire logic              ccw_pulse_input,
    input  wire logic              auto_identify_switch,
    input  wire logic              switch_current_sel,
    input  wire logic [9:0]        switch_peak_current,
    output logic                   microstep_advance,
    output logic                   microstep_dir,
    output logic [9:0]             microsteps_per_step,
    output logic [9:0]             peak_current_setting,
    output logic [15:0]            damping_coefficient,
    output logic [15:0]            proportional_gain,
    output logic [15:0]            integral_gain,
    output logic                   identify_start,
    output logic                   step_test_active,
    output logic [15:0]            baud_divisor,
    output logic [POS_W-1:0]       position
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [31:0] format_q, format_d;
    logic        a_pulse, b_pulse, sw_level, b_level_dir;

    scic_edge_detect u_step (
        .core_clk (core_clk),
        .reset    (reset),
        .din      (step_pulse_input),
        .fall_sel (format_q[scic_pkg::FMT_FALL_BIT]),
        .level    (),
        .pulse    (a_pulse)
    );
    scic_edge_detect u_ccw (
        .core_clk (core_clk),
        .reset    (reset),
        .din      (ccw_pulse_input),
        .fall_sel (format_q[scic_pkg::FMT_FALL_BIT]),
        .level    (),
        .pulse    (b_pulse)
    );
    scic_edge_detect u_dir (
        .core_clk (core_clk),
        .reset    (reset),
        .din      (direction_input),
        .fall_sel (1'b0),
        .level    (b_level_dir),
        .pulse    ()
    );
    scic_edge_detect u_sw (
        .core_clk (core_clk),
        .reset    (reset),
        .din      (auto_identify_switch),
        .fall_sel (1'b0),
        .level    (sw_level),
        .pulse    ()
    );

    // ==========================================================
    // Parameter store
    // ==========================================================
    logic [9:0]  micro_q, micro_d, peak_q, peak_d;
    logic [15:0] damp_q, damp_d, kp_q, kp_d, ki_q, ki_d, baud_q, baud_d;
    logic [31:0] pulser_q, pulser_d;
    logic        wr, rd;
    logic [9:0]  wr_micro, wr_peak;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    always_comb begin
        format_d = format_q;
        micro_d  = micro_q;
        peak_d   = peak_q;
        damp_d   = damp_q;
        kp_d     = kp_q;
        ki_d     = ki_q;
        pulser_d = pulser_q;
        baud_d   = baud_q;
        wr_micro = pwdata[9:0];
        wr_peak  = pwdata[9:0];
        // Bits 9:0 of the write are clamped to range, so the loop never sees garbage.
        if (wr_micro < scic_pkg::MICRO_MIN) wr_micro = scic_pkg::MICRO_MIN;
        if (wr_micro > scic_pkg::MICRO_MAX) wr_micro = scic_pkg::MICRO_MAX;
        if (wr_peak < scic_pkg::PEAK_MIN) wr_peak = scic_pkg::PEAK_MIN;
        if (wr_peak > scic_pkg::PEAK_MAX) wr_peak = scic_pkg::PEAK_MAX;
        if (wr) begin
            unique case (paddr)
                scic_pkg::ADDR_FORMAT: begin
                    format_d = {28'h0, pwdata[3:0]}; // [RULE11]
                end
                scic_pkg::ADDR_MICRO:    micro_d  = wr_micro;   // [RULE6]
                scic_pkg::ADDR_PEAK:     peak_d   = wr_peak;    // [RULE7]
                scic_pkg::ADDR_DAMP:     damp_d   = pwdata[15:0];
                scic_pkg::ADDR_KP:       kp_d     = pwdata[15:0]; // [RULE13]
                scic_pkg::ADDR_KI:       ki_d     = pwdata[15:0]; // [RULE13]
                scic_pkg::ADDR_PULSER:   pulser_d = pwdata;
                scic_pkg::ADDR_PARAMSEL: baud_d   = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            format_q <= 32'h0;
            micro_q  <= scic_pkg::MICRO_RESET;
            peak_q   <= scic_pkg::PEAK_RESET;
            damp_q   <= scic_pkg::DAMP_RESET; // [RULE8]
            kp_q     <= scic_pkg::KP_RESET;
            ki_q     <= scic_pkg::KI_RESET;
            pulser_q <= scic_pkg::PULSER_RESET;
            baud_q   <= 16'(scic_pkg::BAUD_DIV); // [RULE10]
        end else begin
            format_q <= format_d;
            micro_q  <= micro_d;
            peak_q   <= peak_d;
            damp_q   <= damp_d;
            kp_q     <= kp_d;
            ki_q     <= ki_d;
            pulser_q <= pulser_d;
            baud_q   <= baud_d;
        end
    end

    // ==========================================================
    // Internal pulse generator
    // ==========================================================
    // Pulser word: bit 31 enable, bit 30 reverse, bits 23:0 period.
    logic [23:0] pcnt_q, pcnt_d;
    logic        int_pulse;

    always_comb begin
        pcnt_d    = pcnt_q;
        int_pulse = 1'b0;
        if (!pulser_q[31]) begin
            pcnt_d = 24'h0;
        end else if (pcnt_q >= pulser_q[23:0]) begin
            pcnt_d    = 24'h0;
            int_pulse = 1'b1; // [RULE15]
        end else begin
            pcnt_d = pcnt_q + 24'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pcnt_q <= 24'h0;
        end else begin
            pcnt_q <= pcnt_d;
        end
    end

    // ==========================================================
    // Step decode
    // ==========================================================
    logic step_ev, step_dir, use_int;
    logic [POS_W-1:0] pos_q, pos_d;
    logic adv_q, adv_d, mdir_q, mdir_d;

    assign use_int = format_q[scic_pkg::FMT_SRC_BIT];

    always_comb begin
        step_ev = 1'b0;
        step_dir = 1'b0;
        if (use_int) begin
            step_ev  = int_pulse; // [RULE15]
            step_dir = pulser_q[30];
        end else if (format_q[scic_pkg::FMT_DUAL_BIT]) begin
            // Only edges count, so idle input levels are irrelevant. [RULE3]
            step_ev  = a_pulse ^ b_pulse; // [RULE1]
            step_dir = b_pulse;
        end else begin
            step_ev  = a_pulse; // [RULE1]
            // Polarity ignored outside this branch. [RULE5]
            step_dir = b_level_dir ^ format_q[scic_pkg::FMT_DIRHI_BIT]; // [RULE4]
        end
        adv_d  = step_ev;
        mdir_d = step_ev ? step_dir : mdir_q;
        pos_d  = pos_q;
        if (step_ev) begin
            if (step_dir) begin
                pos_d = pos_q - POS_W'(micro_q); // [RULE6]
            end else begin
                pos_d = pos_q + POS_W'(micro_q); // [RULE6]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pos_q  <= '0;
            adv_q  <= 1'b0;
            mdir_q <= 1'b0;
        end else begin
            pos_q  <= pos_d;
            adv_q  <= adv_d;
            mdir_q <= mdir_d;
        end
    end

    // ==========================================================
    // Auto identify and step test
    // ==========================================================
    scic_pkg::scic_id_t id_q, id_d;
    logic [31:0] win_q, win_d;
    logic        ident_q, ident_d;
    logic [15:0] tcnt_q, tcnt_d;
    logic        sw_prev_q, sw_toggle;

    always_comb begin
        id_d    = id_q;
        win_d   = win_q;
        ident_d = 1'b0;
        unique case (id_q)
            scic_pkg::SCIC_ID_IDLE: begin
                win_d = 32'h0;
                if (sw_toggle) begin
                    id_d = scic_pkg::SCIC_ID_ARMED;
                end
            end
            scic_pkg::SCIC_ID_ARMED: begin
                win_d = win_q + 32'h1;
                if (sw_toggle) begin
                    ident_d = 1'b1; // [RULE9]
                    id_d    = scic_pkg::SCIC_ID_IDLE;
                end else if (win_q >= 32'(ID_WINDOW - 1)) begin
                    id_d = scic_pkg::SCIC_ID_IDLE; // [RULE17]
                end
            end
            default: id_d = scic_pkg::SCIC_ID_IDLE;
        endcase
        tcnt_d = tcnt_q;
        if (wr && paddr == scic_pkg::ADDR_TEST && pwdata[0]) begin
            tcnt_d = 16'(scic_pkg::TEST_CYC); // [RULE14]
        end else if (tcnt_q != 16'h0) begin
            tcnt_d = tcnt_q - 16'h1;
        end
    end

    // Toggle detection responds to either edge of the switch.
    assign sw_toggle = sw_level ^ sw_prev_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            id_q      <= scic_pkg::SCIC_ID_IDLE;
            win_q     <= 32'h0;
            ident_q   <= 1'b0;
            tcnt_q    <= 16'h0;
            sw_prev_q <= 1'b0;
        end else begin
            id_q      <= id_d;
            win_q     <= win_d;
            ident_q   <= ident_d;
            tcnt_q    <= tcnt_d;
            sw_prev_q <= sw_level;
        end
    end

    // ==========================================================
    // APB read path
    // ==========================================================
    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        if (rd) begin
            unique case (paddr)
                scic_pkg::ADDR_FORMAT:   prdata = format_q; // [RULE12]
                scic_pkg::ADDR_MICRO:    prdata = {22'h0, micro_q};
                scic_pkg::ADDR_PEAK:     prdata = {22'h0, peak_q};
                scic_pkg::ADDR_DAMP:     prdata = {16'h0, damp_q};
                scic_pkg::ADDR_KP:       prdata = {16'h0, kp_q};
                scic_pkg::ADDR_KI:       prdata = {16'h0, ki_q};
                scic_pkg::ADDR_TEST:     prdata = {31'h0, step_test_active};
                scic_pkg::ADDR_PULSER:   prdata = pulser_q;
                scic_pkg::ADDR_STATUS: begin
                    prdata = {30'h0, id_q == scic_pkg::SCIC_ID_ARMED, mdir_q};
                end
                scic_pkg::ADDR_POSITION: prdata = 32'(pos_q);
                scic_pkg::ADDR_PARAMSEL: prdata = {16'h0, baud_q};
                default:                 pslverr = 1'b1;
            endcase
        end
    end

    assign pready               = 1'b1;
    assign microstep_advance    = adv_q;
    assign microstep_dir        = mdir_q;
    assign microsteps_per_step  = micro_q;
    assign peak_current_setting = switch_current_sel ? // [RULE7]
                                  switch_peak_current : peak_q;
    assign damping_coefficient  = damp_q;
    assign proportional_gain    = kp_q;
    assign integral_gain        = ki_q;
    assign identify_start       = ident_q;
    assign step_test_active     = (tcnt_q != 16'h0);
    assign baud_divisor         = baud_q;
    assign position             = pos_q;
endmodule

//--- logic/scic_pkg.sv
// Constants, types and register map of the step command front end.
package scic_pkg;
    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] ADDR_FORMAT   = 8'h00;
    localparam logic [7:0] ADDR_MICRO    = 8'h04;
    localparam logic [7:0] ADDR_PEAK     = 8'h08;
    localparam logic [7:0] ADDR_DAMP     = 8'h0c;
    localparam logic [7:0] ADDR_KP       = 8'h10;
    localparam logic [7:0] ADDR_KI       = 8'h14;
    localparam logic [7:0] ADDR_TEST     = 8'h18;
    localparam logic [7:0] ADDR_PULSER   = 8'h1c;
    localparam logic [7:0] ADDR_STATUS   = 8'h20;
    localparam logic [7:0] ADDR_POSITION = 8'h24;
    localparam logic [7:0] ADDR_PARAMSEL = 8'h28;
    // ==========================================================
    // Field positions of the format register
    // ==========================================================
    localparam int FMT_DUAL_BIT  = 0;
    localparam int FMT_FALL_BIT  = 1;
    localparam int FMT_DIRHI_BIT = 2;
    localparam int FMT_SRC_BIT   = 3;
    // ==========================================================
    // Reset values and ranges
    // ==========================================================
    localparam logic [9:0]  MICRO_MIN     = 10'h001;
    localparam logic [9:0]  MICRO_MAX     = 10'h200;
    localparam logic [9:0]  MICRO_RESET   = 10'h008;
    // Peak current in units of 10 mA.
    localparam logic [9:0]  PEAK_MIN      = 10'h032;
    localparam logic [9:0]  PEAK_MAX      = 10'h230;
    localparam logic [9:0]  PEAK_RESET    = 10'h12c;
    localparam logic [15:0] DAMP_RESET    = 16'h0bb8;
    localparam logic [15:0] KP_RESET      = 16'h0000;
    localparam logic [15:0] KI_RESET      = 16'h0000;
    localparam logic [31:0] PULSER_RESET  = 32'h0000_0000;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ        = 100_000_000;
    localparam int ID_WINDOW_MS  = 1000;
    localparam int ID_WINDOW_CYC = CLK_HZ / 1000 * ID_WINDOW_MS;
    localparam int BAUD_DEFAULT  = 38400;
    localparam int BAUD_DIV      = CLK_HZ / BAUD_DEFAULT;
    localparam int TEST_CYC      = 1000;
    typedef enum logic [1:0] {SCIC_ID_IDLE, SCIC_ID_ARMED} scic_id_t;
endpackage

//--- logic/scic_edge_detect.sv
// Two-stage synchroniser with selectable edge detector.
`timescale 1ns/100ps
module scic_edge_detect (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic din,
    input  wire logic fall_sel,
    output logic      level,
    output logic      pulse
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Only the second stage feeds the detector, one pulse per edge. [RULE16]
    assign level = sync_q;
    assign pulse = (prev_q ^ sync_q) & (sync_q ^ fall_sel); // [RULE2]
endmodule

//--- sim/scic_top_sva.sv
// Concurrent checks on the ports of the step command front end.
`timescale 1ns/100ps
module scic_top_sva #(
    parameter int POS_W = 32
) (
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             switch_current_sel,
    input wire logic             microstep_advance,
    input wire logic [9:0]       microsteps_per_step,
    input wire logic [9:0]       peak_current_setting,
    input wire logic [15:0]      damping_coefficient,
    input wire logic [15:0]      proportional_gain,
    input wire logic             identify_start,
    input wire logic             step_test_active,
    input wire logic [POS_W-1:0] position
);
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray error");
    property p_bad_rd;
        psel && penable && !pwrite && paddr > 8'h28 |-> pslverr && prdata == 0;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read");
    property p_damp_wr;
        psel && penable && pwrite && paddr == scic_pkg::ADDR_DAMP
        |=> damping_coefficient == $past(pwdata[15:0]);
    endproperty
    a_damp_wr: assert property (p_damp_wr) else $error("damp lost");
    property p_kp_wr;
        psel && penable && pwrite && paddr == scic_pkg::ADDR_KP
        |=> proportional_gain == $past(pwdata[15:0]);
    endproperty
    a_kp_wr: assert property (p_kp_wr) else $error("gain lost");
    property p_micro_rng;
        microsteps_per_step >= scic_pkg::MICRO_MIN &&
        microsteps_per_step <= scic_pkg::MICRO_MAX;
    endproperty
    a_micro_rng: assert property (p_micro_rng) else $error("micro range");
    property p_peak_rng;
        !switch_current_sel && !$past(switch_current_sel)
        |-> peak_current_setting inside {[scic_pkg::PEAK_MIN:scic_pkg::PEAK_MAX]};
    endproperty
    a_peak_rng: assert property (p_peak_rng) else $error("peak range");
    property p_adv_pulse;
        microstep_advance |-> $changed(position);
    endproperty
    a_adv_pulse: assert property (p_adv_pulse) else $error("no move");
    property p_pos_moves;
        $changed(position) |-> microstep_advance || $past(microstep_advance);
    endproperty
    a_pos_moves: assert property (p_pos_moves) else $error("stray move");
    property p_id_pulse;
        identify_start |=> !identify_start [*2];
    endproperty
    a_id_pulse: assert property (p_id_pulse) else $error("long identify");
    property p_test_go;
        psel && penable && pwrite && paddr == scic_pkg::ADDR_TEST && pwdata[0]
        |=> step_test_active [*3];
    endproperty
    a_test_go: assert property (p_test_go) else $error("no test");
    c_step: cover property (microstep_advance);
    c_ident: cover property (identify_start);
    c_err: cover property (pslverr);
    c_test: cover property ($fell(step_test_active));
endmodule
bind scic_top scic_top_sva #(.POS_W(POS_W)) u_sva (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .switch_current_sel(switch_current_sel),
    .microstep_advance(microstep_advance),
    .microsteps_per_step(microsteps_per_step),
    .peak_current_setting(peak_current_setting),
    .damping_coefficient(damping_coefficient),
    .proportional_gain(proportional_gain), .identify_start(identify_start),
    .step_test_active(step_test_active), .position(position)
);

//--- sim/scic_ctrl_model.sv
// Motion controller model that drives the step command lines.
`timescale 1ns/100ps
module scic_ctrl_model (
    input  wire logic core_clk,
    output logic      step_pulse_input,
    output logic      direction_input,
    output logic      ccw_pulse_input
);
    initial begin
        step_pulse_input = 1'b0;
        direction_input = 1'b0;
        ccw_pulse_input = 1'b0;
    end
    // Lines change only after a rising edge; the caller picks the lines
    // of the selected format and holds the idle one.
    task automatic drive(logic s, logic d, logic c);
        @(posedge core_clk);
        step_pulse_input <= s;
        direction_input <= d;
        ccw_pulse_input <= c;
    endtask
endmodule

//--- sim/scic_top_tb_top.sv
// Self-checking bench for the step command front end.
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); \
    end end
module scic_top_tb_top;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic step_l, dir_l, ccw_l, auto_sw, sw_sel, adv, mdir, id_go, t_act;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, position;
    logic [9:0]  sw_peak, micro, peak;
    logic [15:0] damp, kp, ki, baud;
    int          checks_done, mismatches, adv_cnt, id_cnt, cur_micro;
    scic_ctrl_model u_ctrl (.core_clk(core_clk), .step_pulse_input(step_l),
        .direction_input(dir_l), .ccw_pulse_input(ccw_l));
    scic_top #(.ID_WINDOW(100)) dut (.core_clk(core_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_pulse_input(step_l),
        .direction_input(dir_l), .ccw_pulse_input(ccw_l),
        .auto_identify_switch(auto_sw), .switch_current_sel(sw_sel),
        .switch_peak_current(sw_peak), .microstep_advance(adv),
        .microstep_dir(mdir), .microsteps_per_step(micro),
        .peak_current_setting(peak), .damping_coefficient(damp),
        .proportional_gain(kp), .integral_gain(ki), .identify_start(id_go),
        .step_test_active(t_act), .baud_divisor(baud), .position(position));
    // ==========================================================
    // Clock, counters and shared tasks
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Pulses are counted on the falling edge so the count is settled
    // whenever the bench looks at it after a rising edge.
    always @(negedge core_clk) begin
        if (adv === 1'b1) adv_cnt++;
        if (id_go === 1'b1) id_cnt++;
    end
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        if (n >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic reg_case();
        logic [7:0]  ad [9] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
                                8'h0c, 8'h10, 8'h14};
        logic [31:0] wd [9] = '{0, 32'h258, 32'h10, 32'ha, 32'h3ff, 32'hc8,
                                32'h1234, 32'h321, 32'h55};
        logic [31:0] ex [9] = '{1, 32'h200, 32'h10, 32'h32, 32'h230, 32'hc8,
                                32'h1234, 32'h321, 32'h55};
        logic [31:0] q;
        logic e;
        `CHK(damp, scic_pkg::DAMP_RESET)
        `CHK(micro, scic_pkg::MICRO_RESET)
        `CHK(baud, 16'(scic_pkg::BAUD_DIV))
        `CHK({kp, ki}, 32'h0)
        for (int i = 0; i < 9; i++) begin
            wr(ad[i], wd[i]);
            apb(1'b0, ad[i], 0, q, e);
            `CHK(q, ex[i])
        end
        `CHK({damp, kp, ki}, 48'h1234_0321_0055)
        wr(8'h30, 32'h0);
        apb(1'b0, 8'h2c, 0, q, e);
        `CHK({e, q}, 33'h1_0000_0000)
        cur_micro = 16;
    endtask
    task automatic switch_case();
        @(posedge core_clk);
        sw_sel <= 1'b1;
        sw_peak <= 10'h064;
        cyc(4);
        `CHK(peak, 10'h064)
        sw_sel <= 1'b0;
        cyc(4);
        `CHK(peak, 10'h0c8)
    endtask
    // A settling pause after the idle levels are set keeps their own
    // edges out of the counted step.
    task automatic step_case(logic [3:0] f, logic d, logic on_ccw,
                             logic idle, logic rev);
        int a0;
        logic [31:0] p0;
        wr(scic_pkg::ADDR_FORMAT, {28'h0, f});
        u_ctrl.drive(on_ccw ? idle : 1'b0, d, on_ccw ? 1'b0 : idle);
        cyc(8);
        a0 = adv_cnt;
        p0 = position;
        u_ctrl.drive(on_ccw ? idle : 1'b1, d, on_ccw ? 1'b1 : idle);
        cyc(6);
        `CHK(adv_cnt, a0 + (f[1] ? 0 : 1))
        u_ctrl.drive(on_ccw ? idle : 1'b0, d, on_ccw ? 1'b0 : idle);
        cyc(6);
        `CHK(adv_cnt, a0 + 1)
        `CHK(mdir, rev)
        `CHK(position, rev ? p0 - cur_micro : p0 + cur_micro)
    endtask
    task automatic ident_case();
        int i0;
        i0 = id_cnt;
        @(posedge core_clk);
        auto_sw <= ~auto_sw;
        cyc(150);
        `CHK(id_cnt, i0)
        auto_sw <= ~auto_sw;
        cyc(20);
        auto_sw <= ~auto_sw;
        cyc(10);
        `CHK(id_cnt, i0 + 1)
    endtask
    task automatic test_case();
        wr(scic_pkg::ADDR_TEST, 32'h1);
        cyc(500);
        wr(scic_pkg::ADDR_TEST, 32'h1);
        cyc(700);
        `CHK(t_act, 1'b1)
        cyc(400);
        `CHK(t_act, 1'b0)
    endtask
    task automatic pulser_case();
        int a0;
        wr(scic_pkg::ADDR_FORMAT, 32'h8);
        a0 = adv_cnt;
        wr(scic_pkg::ADDR_PULSER, 32'h8000_0014);
        cyc(200);
        wr(scic_pkg::ADDR_PULSER, 32'h0);
        `CHK((adv_cnt - a0) inside {[8:12]}, 1'b1)
    endtask
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {auto_sw, sw_sel, sw_peak} = '0;
        {checks_done, mismatches, adv_cnt, id_cnt, cur_micro} = '0;
        cyc(20);
        reset <= 1'b0;
        reg_case();
        switch_case();
        step_case(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        step_case(4'h0, 1'b1, 1'b0, 1'b0, 1'b1);
        step_case(4'h4, 1'b1, 1'b0, 1'b0, 1'b0);
        step_case(4'h4, 1'b0, 1'b0, 1'b0, 1'b1);
        step_case(4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        step_case(4'h1, 1'b1, 1'b0, 1'b1, 1'b0);
        step_case(4'h5, 1'b0, 1'b1, 1'b1, 1'b1);
        step_case(4'h3, 1'b1, 1'b1, 1'b0, 1'b1);
        ident_case();
        test_case();
        pulser_case();
        conclude();
    end
    initial begin
        cyc(30000);
        mismatches++;
        conclude();
    end
endmodule
